// >>> include/nv_access_pkg.sv
// Constants for the nonvolatile byte access controller
`default_nettype none
package nv_access_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned NV_BYTES      = 4096;
  localparam int unsigned NV_ADDR_W     = 12;
  localparam int unsigned NV_ADDR_HI_W  = NV_ADDR_W - 8;

  // ----------------------------------------------------------------
  // Register byte offsets (one 32-bit word each)
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_CONTROL    = 5'h00;
  localparam logic [4:0] OFS_DATA       = 5'h04;
  localparam logic [4:0] OFS_ADDR_LOW   = 5'h08;
  localparam logic [4:0] OFS_ADDR_HIGH  = 5'h0c;
  localparam logic [4:0] OFS_IRQ_STATUS = 5'h10;
  localparam logic [4:0] OFS_IRQ_MASK   = 5'h14;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int unsigned BIT_READ_STROBE   = 0;
  localparam int unsigned BIT_WRITE_STROBE  = 1;
  localparam int unsigned BIT_MASTER_ENABLE = 2;

  // Interrupt status / mask fields
  localparam int unsigned IRQ_BITS          = 2;
  localparam int unsigned BIT_IRQ_WR_DONE   = 0;
  localparam int unsigned BIT_IRQ_WR_REFUSE = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]          RST_DATA = 8'h00;
  localparam logic [NV_ADDR_W-1:0] RST_ADDR = 12'h000;
  localparam logic [IRQ_BITS-1:0]  RST_MASK = 2'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam logic [2:0] READ_STALL_CYCLES  = 3'h4;
  localparam logic [2:0] WRITE_STALL_CYCLES = 3'h2;
  localparam logic [2:0] MPE_HOLD_CYCLES    = 3'h4;
  localparam int unsigned WRITE_OSC_CYCLES  = 26368;
  localparam int unsigned WRITE_TIME_US_TYP = 3300;
  localparam int unsigned OSC_CNT_W         = 15;

endpackage : nv_access_pkg
`default_nettype wire

// >>> rtl/nv_byte_store.sv
// Byte-wide nonvolatile store model with registered read port
`timescale 1ns/1ns
`default_nettype none
module nv_byte_store
#(
  parameter int unsigned DEPTH  = 4096,
  parameter int unsigned ADDR_W = 12
)
(
  // Clock
  input  wire logic              sys_clk,
  // Write port
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [7:0]        wr_data,
  // Read port
  input  wire logic              rd_en,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [7:0]        rd_data_r
);

  logic [7:0] cells [DEPTH];

  // Cells hold across reset, like the real array
  always_ff @(posedge sys_clk)
  begin
    if (wr_en)
    begin
      cells[wr_addr] <= wr_data;
    end
  end

  // Registered read, one cycle latency
  always_ff @(posedge sys_clk)
  begin
    if (rd_en)
    begin
      rd_data_r <= cells[rd_addr];
    end
  end

endmodule : nv_byte_store
`default_nettype wire

// >>> rtl/nv_access_ctrl.sv
// Processor access controller for the nonvolatile byte store
`timescale 1ns/1ns
`default_nettype none
module nv_access_ctrl
  import nv_access_pkg::*;
#(
  parameter int unsigned WRITE_OSC = WRITE_OSC_CYCLES
)
(
  // Clock and resets
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        por_resetn,
  // Calibrated oscillator, one pulse per cycle
  input  wire logic        rc_tick,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Interrupt and status
  output logic             irq,
  output logic             write_busy
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic                 pending_r;
  logic [2:0]           stall_r;
  logic                 wait_r;
  logic [31:0]          rdata_r;
  logic [7:0]           data_r;
  logic [NV_ADDR_W-1:0] addr_r;
  logic [2:0]           mpe_cnt_r;
  logic                 load_r;
  logic [IRQ_BITS-1:0]  status_r;
  logic [IRQ_BITS-1:0]  mask_r;
  logic                 irq_r;
  logic                 busy_r;
  logic [OSC_CNT_W-1:0] osc_cnt_r;
  logic [NV_ADDR_W-1:0] wr_addr_r;
  logic [7:0]           wr_data_r;
  logic                 done_r;
  logic [7:0]           mem_rdata;
  logic                 accept;
  logic                 ack;
  logic                 wr_ctl;
  logic                 rd_strobe;
  logic                 wr_strobe;
  logic                 wr_start;
  logic                 wr_refuse;
  logic                 wr_finish;
  logic [IRQ_BITS-1:0]  status_nxt;
  logic [31:0]          rdata_nxt;

  // ----------------------------------------------------------------
  // Bus request decode
  // ----------------------------------------------------------------
  // Commit happens in the first cycle a request is seen
  assign accept    = (avs_read | avs_write) & ~pending_r;
  assign ack       = pending_r & ~wait_r;
  assign wr_ctl    = accept & avs_write & avs_byteenable[0]
                   & (avs_address == OFS_CONTROL);
  assign rd_strobe = wr_ctl & avs_writedata[BIT_READ_STROBE];
  assign wr_strobe = wr_ctl & avs_writedata[BIT_WRITE_STROBE];
  // Enable must still be live and engine idle
  assign wr_start  = wr_strobe & (mpe_cnt_r != 3'h0) & ~busy_r;
  assign wr_refuse = wr_strobe & ~wr_start;
  assign wr_finish = busy_r & rc_tick
                   & (osc_cnt_r == OSC_CNT_W'(WRITE_OSC - 1));

  // Stall counter then one-cycle acknowledge
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pending_r <= 1'b0;
      stall_r   <= 3'h0;
      wait_r    <= 1'b1;
    end
    else if (accept)
    begin
      pending_r <= 1'b1;
      if (rd_strobe)
        stall_r <= READ_STALL_CYCLES;
      else if (wr_start)
        stall_r <= WRITE_STALL_CYCLES;
      else
        stall_r <= 3'h0;
    end
    else if (ack)
    begin
      pending_r <= 1'b0;
      wait_r    <= 1'b1;
    end
    else if (pending_r)
    begin
      if (stall_r != 3'h0)
        stall_r <= stall_r - 3'h1;
      else
        wait_r  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Address, data and enable registers
  // ----------------------------------------------------------------
  // Address split over two byte registers
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      addr_r <= RST_ADDR;
    end
    else if (accept & avs_write & avs_byteenable[0])
    begin
      if (avs_address == OFS_ADDR_LOW)
        addr_r[7:0] <= avs_writedata[7:0];
      else if (avs_address == OFS_ADDR_HIGH)
        addr_r[NV_ADDR_W-1:8] <= avs_writedata[NV_ADDR_HI_W-1:0];
    end
  end

  // Data register: software write or byte fetched by read strobe
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      data_r <= RST_DATA;
      load_r <= 1'b0;
    end
    else
    begin
      load_r <= rd_strobe;
      if (load_r)
        data_r <= mem_rdata;
      else if (accept & avs_write & avs_byteenable[0]
               & (avs_address == OFS_DATA))
        data_r <= avs_writedata[7:0];
    end
  end

  // Master enable lives only a few cycles, shrinking stray-write risk
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mpe_cnt_r <= 3'h0;
    end
    else if (wr_ctl & avs_writedata[BIT_MASTER_ENABLE])
    begin
      mpe_cnt_r <= MPE_HOLD_CYCLES;
    end
    else if (wr_start)
    begin
      mpe_cnt_r <= 3'h0;
    end
    else if (mpe_cnt_r != 3'h0)
    begin
      mpe_cnt_r <= mpe_cnt_r - 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Self-timed write engine
  // ----------------------------------------------------------------
  // Only power-on reset clears it, so a system reset lets the write end
  always_ff @(posedge sys_clk or negedge por_resetn)
  begin
    if (!por_resetn)
    begin
      busy_r    <= 1'b0;
      osc_cnt_r <= '0;
      wr_addr_r <= RST_ADDR;
      wr_data_r <= RST_DATA;
      done_r    <= 1'b0;
    end
    else
    begin
      done_r <= wr_finish;
      if (wr_start)
      begin
        busy_r    <= 1'b1;
        osc_cnt_r <= '0;
        wr_addr_r <= addr_r;
        wr_data_r <= data_r;
      end
      else if (wr_finish)
      begin
        busy_r <= 1'b0;
      end
      else if (busy_r & rc_tick)
      begin
        osc_cnt_r <= osc_cnt_r + OSC_CNT_W'(1);
      end
    end
  end

  // Separate byte space, reachable only through these registers
  nv_byte_store
  #(
    .DEPTH  (NV_BYTES),
    .ADDR_W (NV_ADDR_W)
  )
  u_store
  (
    .sys_clk   (sys_clk),
    .wr_en     (wr_finish),
    .wr_addr   (wr_addr_r),
    .wr_data   (wr_data_r),
    .rd_en     (rd_strobe),
    .rd_addr   (addr_r),
    .rd_data_r (mem_rdata)
  );

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  // Cleared on the edge that captures it, so no event slips in between;
  // a new event on that same edge wins
  always_comb
  begin
    status_nxt = status_r;
    if (pending_r & wait_r & (stall_r == 3'h0) & avs_read
        & (avs_address == OFS_IRQ_STATUS))
      status_nxt = '0;
    if (done_r)
      status_nxt[BIT_IRQ_WR_DONE] = 1'b1;
    if (wr_refuse)
      status_nxt[BIT_IRQ_WR_REFUSE] = 1'b1;
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      status_r <= '0;
      mask_r   <= RST_MASK;
      irq_r    <= 1'b0;
    end
    else
    begin
      status_r <= status_nxt;
      irq_r    <= |(status_nxt & mask_r);
      if (accept & avs_write & avs_byteenable[0]
          & (avs_address == OFS_IRQ_MASK))
        mask_r <= avs_writedata[IRQ_BITS-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Unmapped addresses read zero
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    case (avs_address)
      OFS_CONTROL:
      begin
        rdata_nxt[BIT_WRITE_STROBE]  = busy_r;
        rdata_nxt[BIT_MASTER_ENABLE] = (mpe_cnt_r != 3'h0);
      end
      OFS_DATA:       rdata_nxt[7:0] = data_r;
      OFS_ADDR_LOW:   rdata_nxt[7:0] = addr_r[7:0];
      OFS_ADDR_HIGH:  rdata_nxt[NV_ADDR_HI_W-1:0] = addr_r[NV_ADDR_W-1:8];
      OFS_IRQ_STATUS: rdata_nxt[IRQ_BITS-1:0] = status_r;
      OFS_IRQ_MASK:   rdata_nxt[IRQ_BITS-1:0] = mask_r;
      default:        rdata_nxt = 32'h0000_0000;
    endcase
  end

  // Captured when the acknowledge is raised
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      rdata_r <= 32'h0000_0000;
    else if (pending_r & wait_r & (stall_r == 3'h0))
      rdata_r <= rdata_nxt;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;
  assign irq             = irq_r;
  assign write_busy      = busy_r;

endmodule : nv_access_ctrl
`default_nettype wire

// >>> dv/nv_access_ctrl_properties.sv
// Checker for bus timing and write engine of nv_access_ctrl
`timescale 1ns/1ns
`default_nettype none
module nv_access_ctrl_chk
  import nv_access_pkg::*;
#(
  parameter int unsigned WRITE_OSC = WRITE_OSC_CYCLES
)
(
  // Clock, resets, oscillator
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic        por_resetn,
  input wire logic        rc_tick,
  // Bus
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Status
  input wire logic        irq,
  input wire logic        write_busy
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic [15:0] ticks_r;
  // Ticks of the running write; system reset must not clear it
  always_ff @(posedge sys_clk or negedge por_resetn)
    if (!por_resetn) ticks_r <= 16'h0;
    else if (!write_busy) ticks_r <= 16'h0;
    else if (rc_tick) ticks_r <= ticks_r + 16'h1;
  // Answer stands one cycle only
  sequence s_ack;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  property p_plain_read;
    $rose(avs_read) |-> avs_waitrequest[*2] ##1 s_ack;
  endproperty
  a_plain_read: assert property (p_plain_read)
    else $error("plain read answer late or early");
  property p_read_stall;
    $rose(avs_write) && avs_address == OFS_CONTROL && avs_writedata[0]
      |-> avs_waitrequest[*6] ##1 s_ack;
  endproperty
  a_read_stall: assert property (p_read_stall)
    else $error("read strobe stall wrong");
  property p_write_stall;
    $rose(write_busy) |-> avs_waitrequest[*3] ##1 s_ack;
  endproperty
  a_write_stall: assert property (p_write_stall)
    else $error("write strobe stall wrong");
  property p_busy_len;
    disable iff (!por_resetn)
    write_busy && rc_tick && ticks_r == WRITE_OSC - 1 |=> !write_busy;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("write not done after tick count");
  property p_busy_hold;
    disable iff (!por_resetn)
    write_busy && !(rc_tick && ticks_r == WRITE_OSC - 1) |=> write_busy;
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("write ended early");
  property p_reset_bus;
    disable iff (!por_resetn)
    !resetn |-> avs_waitrequest && !irq && avs_readdata == 32'h0;
  endproperty
  a_reset_bus: assert property (p_reset_bus)
    else $error("bus side not cleared in reset");
  property p_unmapped;
    avs_read && !avs_waitrequest && avs_address > OFS_IRQ_MASK
      |-> avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_strobe_zero;
    avs_read && !avs_waitrequest && avs_address == OFS_CONTROL
      |-> !avs_readdata[BIT_READ_STROBE]
          && avs_readdata[BIT_WRITE_STROBE] == $past(write_busy);
  endproperty
  a_strobe_zero: assert property (p_strobe_zero)
    else $error("control read strobe or busy bit wrong");
endmodule : nv_access_ctrl_chk
bind nv_access_ctrl nv_access_ctrl_chk #(.WRITE_OSC(WRITE_OSC)) i_chk (
  .sys_clk(sys_clk), .resetn(resetn), .por_resetn(por_resetn),
  .rc_tick(rc_tick), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .irq(irq), .write_busy(write_busy));
`default_nettype wire

// >>> dv/nv_access_ctrl_bench.sv
// Self-checking bench for nv_access_ctrl
`timescale 1ns/1ns
`default_nettype none
module nv_access_ctrl_bench;
  import nv_access_pkg::*;
  localparam int unsigned OSC = 8;
  logic sys_clk = 1'b0, resetn = 1'b0, por_resetn = 1'b0, rc_tick = 1'b0;
  logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, irq, write_busy;
  logic [4:0]  avs_address = 5'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [1:0]  tdiv = 2'h0;
  int          fails = 0, compares = 0;
  nv_access_ctrl #(.WRITE_OSC(OSC)) i_nv_access_ctrl (
    .sys_clk(sys_clk), .resetn(resetn), .por_resetn(por_resetn),
    .rc_tick(rc_tick), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .write_busy(write_busy));
  always #10 sys_clk = ~sys_clk;
  // Slow oscillator, one tick every third cycle
  always @(posedge sys_clk)
  begin
    tdiv <= (tdiv == 2'h2) ? 2'h0 : tdiv + 2'h1;
    rc_tick <= (tdiv == 2'h2);
  end
  task automatic final_report();
    $display("Compares %0d, errors %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task automatic chk(input string what, input logic [31:0] exp, got);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  // One transfer; rel drops the request, else the next one follows at once
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d, input logic rel);
    int n;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0)
    begin
      fails++;
      final_report();
    end
    rd = avs_readdata;
    if (rel)
    begin
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge sys_clk);
    end
  endtask : bus
  task automatic rdc(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 1'b1);
    chk("register", e, rd);
  endtask : rdc
  task automatic poll_idle();
    int n;
    n = 0;
    do
    begin
      bus(1'b0, OFS_CONTROL, 32'h0, 1'b1);
      n++;
    end
    while (rd[BIT_WRITE_STROBE] !== 1'b0 && n < 40);
    if (rd[BIT_WRITE_STROBE] !== 1'b0)
    begin
      fails++;
      final_report();
    end
  endtask : poll_idle
  task automatic set_addr(input logic [11:0] a);
    bus(1'b1, OFS_ADDR_HIGH, {28'h0, a[11:8]}, 1'b1);
    bus(1'b1, OFS_ADDR_LOW, {24'h0, a[7:0]}, 1'b1);
  endtask : set_addr
  task automatic t_store(input logic [11:0] a, input logic [7:0] d);
    poll_idle();
    set_addr(a);
    bus(1'b1, OFS_DATA, {24'h0, d}, 1'b1);
    bus(1'b1, OFS_CONTROL, 32'h4, 1'b0);
    bus(1'b1, OFS_CONTROL, 32'h2, 1'b1);
    chk("busy", 32'h1, {31'h0, write_busy});
  endtask : t_store
  task automatic t_load(input logic [11:0] a, input logic [7:0] e);
    set_addr(a);
    bus(1'b1, OFS_CONTROL, 32'h1, 1'b1);
    rdc(OFS_DATA, {24'h0, e});
  endtask : t_load
  // Reset values, unmapped place, width of the high address byte
  task automatic t_reset_values();
    logic [4:0] ofs [7];
    ofs = '{OFS_CONTROL, OFS_DATA, OFS_ADDR_LOW, OFS_ADDR_HIGH,
            OFS_IRQ_STATUS, OFS_IRQ_MASK, 5'h18};
    foreach (ofs[i]) rdc(ofs[i], 32'h0);
    bus(1'b1, 5'h18, 32'hff, 1'b1);
    rdc(5'h18, 32'h0);
    bus(1'b1, OFS_ADDR_HIGH, 32'hff, 1'b1);
    rdc(OFS_ADDR_HIGH, 32'hf);
  endtask : t_reset_values
  // Two writes far apart in the space, done interrupt, read back
  task automatic t_write_read();
    bus(1'b1, OFS_IRQ_MASK, 32'h1, 1'b1);
    t_store(12'hfff, 8'ha5);
    poll_idle();
    repeat (2) @(posedge sys_clk);
    chk("irq", 32'h1, {31'h0, irq});
    rdc(OFS_IRQ_STATUS, 32'h1);
    chk("irq", 32'h0, {31'h0, irq});
    t_store(12'h5a3, 8'h3c);
    poll_idle();
    rdc(OFS_IRQ_STATUS, 32'h1);
    t_load(12'hfff, 8'ha5);
    t_load(12'h5a3, 8'h3c);
  endtask : t_write_read
  // Strobe without enable, and after the enable has lapsed
  task automatic t_refuse();
    bus(1'b1, OFS_CONTROL, 32'h2, 1'b1);
    chk("busy", 32'h0, {31'h0, write_busy});
    chk("irq", 32'h0, {31'h0, irq});
    rdc(OFS_IRQ_STATUS, 32'h2);
    bus(1'b1, OFS_CONTROL, 32'h4, 1'b1);
    bus(1'b1, OFS_DATA, 32'h11, 1'b1);
    bus(1'b1, OFS_CONTROL, 32'h2, 1'b1);
    chk("busy", 32'h0, {31'h0, write_busy});
    rdc(OFS_IRQ_STATUS, 32'h2);
  endtask : t_refuse
  // System reset in mid-write must not lose the byte
  task automatic t_reset_mid();
    t_store(12'h123, 8'h96);
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    chk("busy", 32'h1, {31'h0, write_busy});
    poll_idle();
    t_load(12'h123, 8'h96);
  endtask : t_reset_mid
  initial
  begin
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    por_resetn <= 1'b1;
    @(posedge sys_clk);
    t_reset_values();
    t_write_read();
    t_refuse();
    t_reset_mid();
    final_report();
  end
endmodule : nv_access_ctrl_bench
`default_nettype wire
